// File: rtl/ipx_crossbar.sv
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
// How it works
// R1 - default pins follow data, direction, feature registers
// R2 - enabled peripheral takes pin direction and features
// R3 - data and direction registers act on whole port
// R4 - feature register accesses one addressed pin
// R5 - six settings: two drives, four input modes
// R6 - analog use leaves digital configuration untouched
// R7 - fixed priority resolves digital pin conflicts
// R8 - digital block gets all pins or none
// R9 - analog connects only selected channel and reference
// R10 - comparator shares converter pin selection fields
// R11 - digital and analog coexist; analog conflicts by priority
// R12 - crystal oscillator requests analog or digital pins
// R13 - no requests means default general-purpose pinout
// R14 - after reset every pin is digital input
// R15 - input feeds secondary; output ANDs serial transmit
// R16 - pin count set per package: 7, 15, 31
// R17 - slave data out drives only while selected
// R18 - flash programming claims pins only in programming mode
// R19 - register writes affect pins next cycle
// R20 - grants re-evaluated every clock cycle
module ipx_crossbar #(
    parameter int NPINS = ipx_pkg::PINS_LARGE,
    parameter int CHSEL_W = 5,
    parameter int REF_PIN = 0,
    parameter logic [NPINS-1:0] XOSC_ANA_MASK = '0,
    parameter logic [NPINS-1:0] SLV_DOUT_MASK = '0
) (
    // system
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // pads
    input wire logic [NPINS-1:0] PIN_IN,
    output logic [NPINS-1:0] PIN_OUT,
    output logic [NPINS-1:0] PIN_OE,
    output logic [NPINS-1:0] PIN_HIGH_DRIVE,
    output logic [NPINS-1:0] PIN_PULL_UP,
    output logic [NPINS-1:0] PIN_PULL_DOWN,
    output logic [NPINS-1:0] PIN_IN_EN,
    output logic [NPINS-1:0] PIN_ANA_XOSC,
    output logic [NPINS-1:0] PIN_ANA_CONV,
    // default-pinout secondary functions
    input wire logic [NPINS-1:0] UART_TXD,
    output logic [NPINS-1:0] ALT_IN,
    // digital peripheral requests
    input wire logic [ipx_pkg::NUM_BLOCKS-1:0] BLK_EN,
    input wire logic [ipx_pkg::NUM_BLOCKS*NPINS-1:0] BLK_MASK,
    input wire logic [ipx_pkg::NUM_BLOCKS*NPINS-1:0] BLK_OE,
    input wire logic [ipx_pkg::NUM_BLOCKS*NPINS-1:0] BLK_DO,
    output logic [ipx_pkg::NUM_BLOCKS-1:0] BLK_GRANT,
    // special request qualifiers
    input wire logic XOSC_EN,
    input wire logic XOSC_ANALOG,
    input wire logic PROGRAMMING_MODE_INPUT_MODE_IN,
    input wire logic SLV_SEL_N,
    // analog requests
    input wire logic CONV_EN,
    input wire logic CMP_EN,
    input wire logic [CHSEL_W-1:0] CONV_CHANNEL_SEL,
    input wire logic CONV_REFERENCE_SEL
);
    localparam int NB = ipx_pkg::NUM_BLOCKS;
    localparam int NP = (NPINS + 7) / 8;
    localparam int PW = NP * 8;
    localparam int NREG = NP * 4;

    typedef struct packed {
        logic [PW-1:0] dat;
        logic [PW-1:0] dir;
        logic [PW-1:0] drv;
        logic [PW-1:0] pu;
        logic [PW-1:0] pd;
        logic [PW-1:0] ioff;
        logic [NP*4-1:0] fptr;
        logic ack;
        logic [31:0] rdat;
    } ipx_state_t;

    ipx_state_t st_r;
    ipx_state_t st_nxt;

    logic [NB-1:0] en_eff;
    logic [NB-1:0] grant;
    logic [NPINS-1:0] owned;
    logic [NPINS-1:0] x_oe;
    logic [NPINS-1:0] x_do;
    logic [NPINS-1:0] conv_sel;
    logic [NPINS-1:0] xosc_ana;
    logic [PW-1:0] pin_in_pad;
    logic req;
    logic [5:0] idx;
    logic [3:0] port;
    logic [1:0] kind;

    // special enables: oscillator digital only when not analog, flash only in programming_mode_input mode
    always_comb begin
        en_eff = BLK_EN;
        en_eff[ipx_pkg::BLK_XOSC] = XOSC_EN & ~XOSC_ANALOG; // R12
        en_eff[ipx_pkg::BLK_FLASH_SPI] = BLK_EN[ipx_pkg::BLK_FLASH_SPI] & PROGRAMMING_MODE_INPUT_MODE_IN; // R18
    end

    // grants are purely combinational, so they follow the inputs every cycle
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            grant[i] = en_eff[i]; // R20
            for (int j = 0; j < i; j++) begin
                // any overlap with an enabled higher block drops the whole request
                if (en_eff[j] && |(BLK_MASK[j*NPINS +: NPINS] & BLK_MASK[i*NPINS +: NPINS])) begin
                    grant[i] = 1'b0; // R7 R8
                end
            end
        end
    end

    // per pin: the granted block owning it steers direction and data
    always_comb begin
        owned = '0;
        x_oe = '0;
        x_do = '0;
        for (int p = 0; p < NPINS; p++) begin
            for (int i = NB - 1; i >= 0; i--) begin
                if (grant[i] && BLK_MASK[i*NPINS + p]) begin
                    owned[p] = 1'b1; // R2
                    x_oe[p] = BLK_OE[i*NPINS + p];
                    x_do[p] = BLK_DO[i*NPINS + p];
                    if (i == ipx_pkg::BLK_SPI_SLAVE && SLV_DOUT_MASK[p]) begin
                        x_oe[p] = BLK_OE[i*NPINS + p] & ~SLV_SEL_N; // R17
                    end
                end
            end
        end
    end

    // analog: only the selected channel and reference pins; comparator uses the same fields
    always_comb begin
        conv_sel = '0;
        if (CONV_EN || CMP_EN) begin // R10
            for (int p = 0; p < NPINS; p++) begin
                if (CONV_CHANNEL_SEL == CHSEL_W'(p)) begin
                    conv_sel[p] = 1'b1; // R9
                end
            end
            if (CONV_REFERENCE_SEL == ipx_pkg::REF_EXTERNAL) begin
                conv_sel[REF_PIN] = 1'b1; // R9
            end
        end
        xosc_ana = (XOSC_EN && XOSC_ANALOG) ? XOSC_ANA_MASK : '0; // R12
    end

    // the oscillator outranks the converter; digital settings are never touched here
    assign PIN_ANA_XOSC = xosc_ana; // R6 R11
    assign PIN_ANA_CONV = conv_sel & ~xosc_ana; // R11

    // pad drive: registers by default, crossbar where a block owns the pin
    always_comb begin
        for (int p = 0; p < NPINS; p++) begin
            if (owned[p]) begin
                PIN_OE[p] = x_oe[p]; // R2
                PIN_OUT[p] = x_do[p];
                PIN_HIGH_DRIVE[p] = 1'b0;
                PIN_PULL_UP[p] = 1'b0;
                PIN_PULL_DOWN[p] = 1'b0;
                PIN_IN_EN[p] = 1'b1;
            end else begin
                PIN_OE[p] = st_r.dir[p]; // R1 R13
                PIN_OUT[p] = st_r.dat[p] & UART_TXD[p]; // R15
                PIN_HIGH_DRIVE[p] = st_r.drv[p];
                PIN_PULL_UP[p] = st_r.pu[p];
                PIN_PULL_DOWN[p] = st_r.pd[p];
                PIN_IN_EN[p] = ~st_r.ioff[p];
            end
            // idle-high secondary input unless the pin is a default input
            ALT_IN[p] = (!owned[p] && !st_r.dir[p]) ? PIN_IN[p] : 1'b1; // R15
        end
    end

    assign BLK_GRANT = grant;
    assign WB_DAT_O = st_r.rdat;
    assign WB_ACK_O = st_r.ack;
    assign pin_in_pad = PW'(PIN_IN);
    assign req = WB_CYC_I & WB_STB_I & ~st_r.ack;
    assign idx = WB_ADR_I[7:2];
    assign port = idx[5:2];
    assign kind = idx[1:0];

    // bus slave and register file
    always_comb begin
        int pin;
        logic [3:0] fp;
        logic [7:0] rd;
        pin = 0;
        fp = '0;
        rd = '0;
        st_nxt = st_r;
        st_nxt.ack = req;
        st_nxt.rdat = '0;
        if (req && int'(idx) < NREG) begin
            fp = st_r.fptr[port*4 +: 4];
            pin = int'(port) * 8 + int'(fp[2:0]);
            unique case (kind)
                ipx_pkg::OFS_DATA[3:2]: begin
                    // inputs read the pad, outputs read the latch
                    for (int b = 0; b < 8; b++) begin
                        rd[b] = st_r.dir[port*8 + b] ? st_r.dat[port*8 + b] : pin_in_pad[port*8 + b];
                    end
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        st_nxt.dat[port*8 +: 8] = WB_DAT_I[7:0]; // R3 R19
                    end
                end
                ipx_pkg::OFS_DIR[3:2]: begin
                    rd = st_r.dir[port*8 +: 8];
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        st_nxt.dir[port*8 +: 8] = WB_DAT_I[7:0]; // R3 R19
                    end
                end
                ipx_pkg::OFS_FEAT[3:2]: begin
                    rd[ipx_pkg::FEAT_PIN_LSB +: 4] = fp;
                    if (fp[ipx_pkg::FEAT_SIDE_BIT]) begin
                        rd[ipx_pkg::FEAT_CODE_LSB +: ipx_pkg::FEAT_CODE_W] =
                            st_r.drv[pin] ? ipx_pkg::OUT_HIGH : ipx_pkg::OUT_NORMAL;
                    end else if (st_r.ioff[pin]) begin
                        rd[ipx_pkg::FEAT_CODE_LSB +: ipx_pkg::FEAT_CODE_W] = ipx_pkg::IN_BUF_OFF;
                    end else if (st_r.pu[pin]) begin
                        rd[ipx_pkg::FEAT_CODE_LSB +: ipx_pkg::FEAT_CODE_W] = ipx_pkg::IN_PULL_UP;
                    end else if (st_r.pd[pin]) begin
                        rd[ipx_pkg::FEAT_CODE_LSB +: ipx_pkg::FEAT_CODE_W] = ipx_pkg::IN_PULL_DOWN;
                    end
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        fp = WB_DAT_I[3:0];
                        st_nxt.fptr[port*4 +: 4] = fp; // R4
                        pin = int'(port) * 8 + int'(fp[2:0]);
                        if (fp[ipx_pkg::FEAT_SIDE_BIT]) begin
                            st_nxt.drv[pin] = (WB_DAT_I[ipx_pkg::FEAT_CODE_LSB +: 2]
                                == ipx_pkg::OUT_HIGH); // R5
                        end else begin
                            unique case (WB_DAT_I[ipx_pkg::FEAT_CODE_LSB +: 2])
                                ipx_pkg::IN_NO_PULL: begin
                                    st_nxt.pu[pin] = 1'b0; // R5
                                    st_nxt.pd[pin] = 1'b0;
                                    st_nxt.ioff[pin] = 1'b0;
                                end
                                ipx_pkg::IN_PULL_UP: begin
                                    st_nxt.pu[pin] = 1'b1;
                                    st_nxt.pd[pin] = 1'b0;
                                    st_nxt.ioff[pin] = 1'b0;
                                end
                                ipx_pkg::IN_PULL_DOWN: begin
                                    st_nxt.pu[pin] = 1'b0;
                                    st_nxt.pd[pin] = 1'b1;
                                    st_nxt.ioff[pin] = 1'b0;
                                end
                                ipx_pkg::IN_BUF_OFF: begin
                                    st_nxt.pu[pin] = 1'b0;
                                    st_nxt.pd[pin] = 1'b0;
                                    st_nxt.ioff[pin] = 1'b1;
                                end
                            endcase
                        end
                    end
                end
                default: begin
                    rd = '0;
                end
            endcase
            st_nxt.rdat = {24'h000000, rd};
        end else if (req && WB_ADR_I == ipx_pkg::ADDR_GRANT) begin
            st_nxt.rdat = 32'(grant);
        end else if (req && WB_ADR_I == ipx_pkg::ADDR_OWNED) begin
            st_nxt.rdat = 32'(owned);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_r.dat <= {NP{ipx_pkg::RST_DATA}};
            st_r.dir <= {NP{ipx_pkg::RST_DIR}}; // R14
            st_r.drv <= {NP{ipx_pkg::RST_FEAT}};
            st_r.pu <= {NP{ipx_pkg::RST_FEAT}};
            st_r.pd <= {NP{ipx_pkg::RST_FEAT}};
            st_r.ioff <= {NP{ipx_pkg::RST_FEAT}};
            st_r.fptr <= '0;
            st_r.ack <= 1'b0;
            st_r.rdat <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pin count comes from NPINS; the package variants are 7, 15 and 31
    localparam bit PINS_OK = (NPINS == ipx_pkg::PINS_SMALL) || (NPINS == ipx_pkg::PINS_MEDIUM)
        || (NPINS == ipx_pkg::PINS_LARGE); // R16

endmodule : ipx_crossbar

// File: rtl/ipx_pkg.sv
package ipx_pkg;
    // register map, byte addresses on the bus
    localparam logic [7:0] PORT_STRIDE = 8'h10;
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_DIR = 4'h4;
    localparam logic [3:0] OFS_FEAT = 4'h8;
    localparam logic [7:0] ADDR_GRANT = 8'h40;
    localparam logic [7:0] ADDR_OWNED = 8'h44;
    // pin feature register layout
    localparam int FEAT_PIN_LSB = 0;
    localparam int FEAT_PIN_W = 3;
    localparam int FEAT_SIDE_BIT = 3;
    localparam int FEAT_CODE_LSB = 4;
    localparam int FEAT_CODE_W = 2;
    // output-side feature codes
    localparam logic [1:0] OUT_NORMAL = 2'h0;
    localparam logic [1:0] OUT_HIGH = 2'h1;
    // input-side feature codes
    localparam logic [1:0] IN_NO_PULL = 2'h0;
    localparam logic [1:0] IN_PULL_UP = 2'h1;
    localparam logic [1:0] IN_PULL_DOWN = 2'h2;
    localparam logic [1:0] IN_BUF_OFF = 2'h3;
    // reset values: every pin a digital input, buffer on, no pull
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_FEAT = 8'h00;
    // package variants
    localparam int PINS_SMALL = 7;
    localparam int PINS_MEDIUM = 15;
    localparam int PINS_LARGE = 31;
    // fixed priority order of digital blocks, 0 highest
    localparam int BLK_XOSC = 0;
    localparam int BLK_SPI_MASTER = 1;
    localparam int BLK_SPI_SLAVE = 2;
    localparam int BLK_FLASH_SPI = 3;
    localparam int BLK_DEBUG = 4;
    localparam int BLK_TWO_WIRE = 5;
    localparam int BLK_PWM = 6;
    localparam int NUM_BLOCKS = 7;
    // converter reference select: external pin reference
    localparam logic REF_EXTERNAL = 1'b1;
endpackage : ipx_pkg

// File: test/ipx_crossbar_chk.sv
`timescale 1ns/1ps
module ipx_crossbar_chk #(
    parameter int NPINS = 7,
    parameter int CHSEL_W = 5,
    parameter int REF_PIN = 0,
    parameter logic [NPINS-1:0] SLV_DOUT_MASK = '0
) (
    // system
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // pins and requests
    input wire logic [NPINS-1:0] PIN_OE,
    input wire logic [NPINS-1:0] PIN_ANA_CONV,
    input wire logic [6:0] BLK_EN,
    input wire logic [7*NPINS-1:0] BLK_MASK,
    input wire logic [6:0] BLK_GRANT,
    input wire logic XOSC_EN,
    input wire logic PROGRAMMING_MODE_INPUT_MODE_IN,
    input wire logic SLV_SEL_N,
    input wire logic CONV_EN,
    input wire logic CMP_EN,
    input wire logic [CHSEL_W-1:0] CONV_CHANNEL_SEL,
    input wire logic CONV_REFERENCE_SEL
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic [6:0] ef;
    logic [6:0] eg;
    logic [NPINS-1:0] ea;
    // a loser still blocks lower blocks, so ef and not eg gates the overlap test
    always_comb begin
        ef = BLK_EN;
        ef[3] = BLK_EN[3] & PROGRAMMING_MODE_INPUT_MODE_IN;
        eg = ef;
        for (int i = 1; i < 7; i++) begin
            for (int j = 0; j < i; j++) begin
                if (ef[j] && |(BLK_MASK[i*NPINS +: NPINS] & BLK_MASK[j*NPINS +: NPINS])) begin
                    eg[i] = 1'b0;
                end
            end
        end
        ea = '0;
        if (CONV_EN || CMP_EN) begin
            ea = NPINS'(1) << CONV_CHANNEL_SEL;
            if (CONV_REFERENCE_SEL == ipx_pkg::REF_EXTERNAL) begin
                ea[REF_PIN] = 1'b1;
            end
        end
    end
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_pulse;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    AST_ACK_PULSE: assert property (s_take |=> s_pulse)
        else $error("ack not a single pulse after a taken request");
    AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without a request");
    AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
        else $error("read data not zero outside ack");
    AST_GRANT_PRIO: assert property (!XOSC_EN && !BLK_EN[0] |-> BLK_GRANT == eg)
        else $error("grant vector differs from priority result");
    AST_FLASH_PROGRAMMING_MODE_INPUT: assert property (!PROGRAMMING_MODE_INPUT_MODE_IN |-> !BLK_GRANT[3])
        else $error("flash block granted outside programming mode");
    AST_SLV_OE: assert property (SLV_SEL_N && BLK_GRANT[2] |-> (PIN_OE & SLV_DOUT_MASK) == '0)
        else $error("slave data out driven while deselected");
    AST_ANA_SEL: assert property (!XOSC_EN |-> PIN_ANA_CONV == ea)
        else $error("analog switches differ from selected channel and reference");
    AST_RESET_IN: assert property (disable iff (1'b0)
        !RST_N |=> (BLK_EN != '0 || XOSC_EN || PIN_OE == '0))
        else $error("pin driven right after reset");
endmodule : ipx_crossbar_chk

bind ipx_crossbar ipx_crossbar_chk #(.NPINS(NPINS), .CHSEL_W(CHSEL_W), .REF_PIN(REF_PIN),
    .SLV_DOUT_MASK(SLV_DOUT_MASK)) i_ipx_crossbar_chk (.*);

// File: test/ipx_periph_model.sv
`timescale 1ns/1ps
module ipx_periph_model #(
    parameter logic [48:0] MASKS = '0
) (
    // bench command
    input wire logic [6:0] want,
    // requests toward the crossbar
    output logic [6:0] en,
    output logic [48:0] mask,
    output logic [48:0] oe,
    output logic [48:0] dout
);
    // a block always asks for its whole pin set, never a part of it
    assign en = want;
    assign mask = MASKS;
    assign oe = MASKS;
    assign dout = MASKS & {7{7'h2a}};
endmodule : ipx_periph_model

// File: test/io_port_crossbar_tb_top.sv
`timescale 1ns/1ps
module io_port_crossbar_tb_top;
    localparam logic [48:0] MK = {7'h48, 7'h60, 7'h78, 7'h3c, 7'h3c, 7'h1c, 7'h03};
    localparam logic [7:0] A_DAT = {4'h0, ipx_pkg::OFS_DATA};
    localparam logic [7:0] A_DIR = {4'h0, ipx_pkg::OFS_DIR};
    localparam logic [7:0] A_FT = {4'h0, ipx_pkg::OFS_FEAT};
    // enables, programming mode, expected grants
    localparam logic [14:0] ROWS [13] = '{{7'h00, 1'b0, 7'h00}, {7'h02, 1'b0, 7'h02},
        {7'h06, 1'b0, 7'h02}, {7'h24, 1'b0, 7'h04}, {7'h60, 1'b0, 7'h20},
        {7'h08, 1'b0, 7'h00}, {7'h08, 1'b1, 7'h08}, {7'h50, 1'b0, 7'h10},
        {7'h22, 1'b0, 7'h22}, {7'h12, 1'b0, 7'h02}, {7'h46, 1'b0, 7'h02},
        {7'h34, 1'b0, 7'h04}, {7'h30, 1'b0, 7'h10}};
    localparam logic [7:0] FT [4] = '{8'h15, 8'h26, 8'h34, 8'h19};
    logic core_clk, rst_n, cyc, stb, we, ack, programming_mode_input, sel_n, xen, xana, cen, pen, rsel;
    logic [7:0] adr;
    logic [4:0] chs;
    logic [3:0] sel, sel_v;
    logic [31:0] wdat, rdat, q;
    logic [6:0] pin_in, txd, want, en, grant, pout, poe, phd, ppu, ppd, pie, pax, pac, alt;
    logic [48:0] bm, bo, bd;
    int bad_count, samples_checked, cyc_cnt;
    ipx_crossbar #(.NPINS(7), .XOSC_ANA_MASK(7'h03), .SLV_DOUT_MASK(7'h10)) i_ipx_crossbar (
        .CORE_CLK(core_clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe), .PIN_HIGH_DRIVE(phd),
        .PIN_PULL_UP(ppu), .PIN_PULL_DOWN(ppd), .PIN_IN_EN(pie), .PIN_ANA_XOSC(pax),
        .PIN_ANA_CONV(pac), .UART_TXD(txd), .ALT_IN(alt), .BLK_EN(en), .BLK_MASK(bm),
        .BLK_OE(bo), .BLK_DO(bd), .BLK_GRANT(grant), .XOSC_EN(xen), .XOSC_ANALOG(xana),
        .PROGRAMMING_MODE_INPUT_MODE_IN(programming_mode_input), .SLV_SEL_N(sel_n), .CONV_EN(cen), .CMP_EN(pen),
        .CONV_CHANNEL_SEL(chs), .CONV_REFERENCE_SEL(rsel));
    ipx_periph_model #(.MASKS(MK)) i_ipx_periph_model (
        .want(want), .en(en), .mask(bm), .oe(bo), .dout(bd));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task conclude;
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // the slave answers in one cycle, but the wait never assumes so
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_v;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        logic [6:0] own;
        {rst_n, cyc, stb, we, programming_mode_input, sel_n, xen, xana, cen, pen, rsel} = '0;
        {adr, chs, wdat, pin_in, want, sel} = '0;
        txd = '1;
        sel_v = 4'h1;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("oe", 0, poe);
        chk("pull", 0, ppu | ppd);
        chk("in_en", 7'h7f, pie);
        bus(1'b0, A_DIR, 8'h00);
        chk("dir", 0, q);
        for (int r = 0; r < 13; r++) begin
            @(posedge core_clk);
            want <= ROWS[r][14:8];
            programming_mode_input <= ROWS[r][7];
            @(negedge core_clk);
            own = '0;
            for (int b = 0; b < 7; b++) if (ROWS[r][b]) own |= MK[b*7 +: 7];
            chk("grant", ROWS[r][6:0], grant);
            chk("oe", own, poe);
            chk("out", own & 7'h2a, pout & own);
        end
        @(posedge core_clk);
        want <= '0;
        programming_mode_input <= 1'b0;
        pin_in <= 7'h50;
        bus(1'b1, A_DAT, 8'h35);
        bus(1'b1, A_DIR, 8'h0f);
        @(negedge core_clk);
        chk("oe", 7'h0f, poe);
        chk("out", 7'h05, pout & 7'h0f);
        chk("alt", 7'h5f, alt);
        bus(1'b0, A_DAT, 8'h00);
        chk("data", 32'h55, q);
        @(posedge core_clk);
        txd <= 7'h7e;
        @(negedge core_clk);
        chk("and", 7'h04, pout & 7'h0f);
        foreach (FT[k]) bus(1'b1, A_FT, FT[k]);
        @(negedge core_clk);
        chk("pu", 7'h20, ppu);
        chk("pd", 7'h40, ppd);
        chk("in_en", 7'h6f, pie);
        chk("hd", 7'h02, phd);
        bus(1'b0, A_FT, 8'h00);
        chk("feat", 32'h19, q);
        bus(1'b1, A_FT, 8'h09);
        bus(1'b1, 8'h80, 8'hff);
        bus(1'b0, 8'h80, 8'h00);
        chk("unmapped", 0, q);
        chk("hd", 0, phd);
        // a write with byte lane 0 off must leave the direction alone
        sel_v = 4'h0;
        bus(1'b1, A_DIR, 8'h00);
        sel_v = 4'h1;
        chk("oe", 7'h0f, poe);
        @(posedge core_clk);
        want <= 7'h20;
        @(negedge core_clk);
        chk("oe", 7'h6f, poe);
        chk("pu", 0, ppu | ppd);
        bus(1'b0, ipx_pkg::ADDR_GRANT, 8'h00);
        chk("grant_reg", 32'h20, q);
        bus(1'b0, ipx_pkg::ADDR_OWNED, 8'h00);
        chk("owned_reg", 32'h60, q);
        @(posedge core_clk);
        want <= 7'h04;
        sel_n <= 1'b1;
        @(negedge core_clk);
        chk("oe", 7'h2f, poe);
        @(posedge core_clk);
        sel_n <= 1'b0;
        @(negedge core_clk);
        chk("oe", 7'h3f, poe);
        @(posedge core_clk);
        want <= '0;
        {cen, chs, rsel} <= {1'b1, 5'h03, 1'b1};
        @(negedge core_clk);
        chk("ana", 7'h09, pac);
        chk("oe", 7'h0f, poe);
        @(posedge core_clk);
        rsel <= 1'b0;
        @(negedge core_clk);
        chk("ana", 7'h08, pac);
        @(posedge core_clk);
        {cen, pen, chs} <= {1'b0, 1'b1, 5'h05};
        @(negedge core_clk);
        chk("ana", 7'h20, pac);
        @(posedge core_clk);
        {xen, xana, chs} <= {1'b1, 1'b1, 5'h01};
        @(negedge core_clk);
        chk("xosc", 7'h03, pax);
        chk("ana", 0, pac);
        // oscillator in digital mode takes its pins through the block 0 slot
        @(posedge core_clk);
        xana <= 1'b0;
        @(negedge core_clk);
        chk("grant", 7'h01, grant);
        chk("xosc", 0, pax);
        chk("out", 7'h02, pout & 7'h03);
        chk("ana", 7'h02, pac);
        // reset in mid-run must drop the written pulls and directions
        @(posedge core_clk);
        {xen, rst_n} <= 2'b00;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk("oe", 0, poe);
        chk("pull", 0, ppu | ppd);
        bus(1'b0, A_DAT, 8'h00);
        chk("data", 32'h50, q);
        conclude();
    end
endmodule : io_port_crossbar_tb_top
